// ===== rtl/transient_pkg.sv
// Shared constants and carriers for the transient event detector.
package transient_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [9:0] CONFIG_IDX = 10'h01D;
  localparam logic [9:0] SOURCE_IDX = 10'h01E;
  localparam logic [9:0] THRESH_IDX = 10'h01F;
  localparam logic [9:0] COUNT_IDX = 10'h020;
  localparam logic [9:0] IRQ_STAT_IDX = 10'h030;
  localparam logic [9:0] IRQ_CLR_IDX = 10'h031;
  localparam logic [9:0] IRQ_EN_IDX = 10'h032;

  // ----------------------------------------------------------------
  // Reset values and scaling
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] SOURCE_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  // Threshold step in micro-g per count, fixed at 63 mg.
  localparam logic [15:0] THS_STEP_UG = 16'hF618;
  localparam int SAMPLE_W = 14;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic signed [SAMPLE_W-1:0] axis_t;

  // One output-data-rate sample; index 0 is X, 1 is Y, 2 is Z.
  typedef struct packed {
    logic tick;
    axis_t [2:0] axis;
  } accel_in_t;

  // Configuration register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [2:0] rsvd;
    logic latch_en;
    logic [2:0] axis_en;
    logic hpf_bypass;
  } transient_config_t;

  // Source register layout; each pair is {flag, polarity}.
  typedef struct packed {
    logic rsvd;
    logic any_event_active;
    logic [2:0][1:0] pair;
  } transient_source_t;

  // Threshold register layout.
  typedef struct packed {
    logic debounce_mode;
    logic [6:0] threshold_value;
  } transient_ths_t;

endpackage

// ===== rtl/hpf_axis.sv
// First-order high-pass filter for one acceleration axis.
`timescale 1ns/1ps
module hpf_axis #(
  parameter int SHIFT = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire transient_pkg::axis_t sample,
  output transient_pkg::axis_t filtered
);
  import transient_pkg::*;

  // Running low-pass estimate of the DC level, with fraction bits.
  logic signed [SAMPLE_W+SHIFT:0] dc_acc;
  // Integer part of the DC estimate.
  logic signed [SAMPLE_W:0] dc_level;
  // Sample minus DC level, one bit wider to avoid wrap.
  logic signed [SAMPLE_W:0] diff;

  assign dc_level = dc_acc[SAMPLE_W+SHIFT:SHIFT];
  assign diff = SAMPLE_W'(sample) - dc_level;

  // ----------------------------------------------------------------
  // DC tracking
  // ----------------------------------------------------------------
  // The estimate moves by a fraction of the error on each sample, so
  // a step input decays away instead of holding the detector tripped.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_acc <= '0;
    end else if (tick) begin
      dc_acc <= dc_acc + (SAMPLE_W+SHIFT+1)'(diff);
    end
  end

  // ----------------------------------------------------------------
  // Output with saturation
  // ----------------------------------------------------------------
  // Saturation keeps a full-scale swing from flipping sign.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filtered <= '0;
    end else if (tick) begin
      if (diff[SAMPLE_W] != diff[SAMPLE_W-1]) begin
        filtered <= diff[SAMPLE_W] ? {1'b1, {(SAMPLE_W-1){1'b0}}}
                                   : {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else begin
        filtered <= diff[SAMPLE_W-1:0];
      end
    end
  end

  // The filter only moves on a sample tick.
  filt_hold_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !tick |=> filtered == $past(filtered))
    else $error("filter output moved without a sample tick");

endmodule // hpf_axis

// ===== rtl/transient_detector.sv
// Transient acceleration event detector with APB register access.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
//
// Behaviour
// - Optional high-pass filter removes DC offset.
// - Event when enabled axis exceeds threshold long enough.
// - Unlatched flag follows real-time detection.
// - Latched flag holds until source read.
// - Per-axis enables; disabled axes ignored.
// - Bypass bit selects raw or filtered input.
// - Config layout: latch, Z/Y/X enables, bypass.
// - Source layout: any flag, axis flag/polarity pairs.
// - Any flag from axis flags; polarity marks negative.
// - Latched freezes; unlatched updates flags and polarity.
// - 7-bit threshold, 63 mg step; debounce mode.
// - 8-bit debounce count sets required steps.
module transient_detector #(
  parameter int HPF_SHIFT = 4,
  // Sample resolution in micro-g per count.
  parameter logic [15:0] SAMPLE_LSB_UG = 16'h03D0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [transient_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire transient_pkg::accel_in_t accel,
  output logic event_active,
  output logic irq
);
  import transient_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  transient_config_t cfg; // Configuration register.
  transient_source_t src; // Source register.
  transient_ths_t ths; // Threshold and debounce mode.
  logic [7:0] debounce_value; // Required debounce steps.
  logic [7:0] deb_cnt; // Running debounce counter.
  logic irq_status; // Sticky event status.
  logic irq_en; // Interrupt enable.

  // ----------------------------------------------------------------
  // Per-axis datapath
  // ----------------------------------------------------------------
  axis_t [2:0] filt; // High-pass filtered samples.
  axis_t [2:0] sel; // Samples fed to detection.
  logic [2:0] over; // Enabled axis beyond threshold.
  logic [2:0] neg; // Axis excursion is negative.
  logic [31:0] ths_ug; // Threshold in micro-g.

  // Threshold scaled once; independent of full-scale range.
  assign ths_ug = 32'(ths.threshold_value) * 32'(THS_STEP_UG);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      logic [SAMPLE_W-1:0] mag; // Magnitude of the sample.
      logic [31:0] mag_ug; // Magnitude in micro-g.

      hpf_axis #(.SHIFT(HPF_SHIFT)) u_hpf (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(accel.tick),
        .sample(accel.axis[gi]),
        .filtered(filt[gi])
      );

      // Bypass picks raw data, which turns this into motion detection.
      assign sel[gi] = cfg.hpf_bypass ? accel.axis[gi]
                                      : filt[gi];
      assign neg[gi] = sel[gi][SAMPLE_W-1];
      // Negation of the most negative code still fits unsigned.
      assign mag = neg[gi] ? SAMPLE_W'(-sel[gi]) : SAMPLE_W'(sel[gi]);
      assign mag_ug = 32'(mag) * 32'(SAMPLE_LSB_UG);
      // A disabled axis never contributes.
      assign over[gi] = cfg.axis_en[gi] && (mag_ug > ths_ug);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Debounce evaluation
  // ----------------------------------------------------------------
  logic cond; // Any enabled axis beyond threshold.
  logic [8:0] cnt_inc; // Counter plus one, unsaturated.
  logic hit; // Condition met for enough steps.
  logic load; // Source takes a new event this cycle.
  logic evt; // Rising edge of the any-event flag.
  transient_source_t next_src; // Freshly captured source value.

  assign cond = |over;
  assign cnt_inc = {1'b0, deb_cnt} + 9'h001;
  // The current tick counts as a step, so a count of N needs N
  // consecutive qualifying samples when debounce_mode is 1 (a zero count needs just one).
  assign hit = accel.tick && cond
            && (cnt_inc >= {1'b0, debounce_value});
  // A latched event freezes until read; otherwise every hit reloads.
  assign load = hit && !(cfg.latch_en && src.any_event_active);
  assign evt = load && !src.any_event_active;

  // Assemble the captured flags; polarity is 1 only when negative.
  always_comb begin
    next_src = SOURCE_RST;
    next_src.any_event_active = |over;
    for (int i = 0; i < 3; i++) begin
      next_src.pair[i] = {over[i], over[i] & neg[i]};
    end
  end

  // Counter steps only on a sample tick, and saturates both ways.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      deb_cnt <= '0;
    end else if (accel.tick) begin
      if (cond) begin
        deb_cnt <= cnt_inc[8] ? deb_cnt : cnt_inc[7:0];
      end else if (ths.debounce_mode) begin
        deb_cnt <= '0;
      end else if (deb_cnt != 8'h00) begin
        deb_cnt <= deb_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  logic [9:0] idx; // Word index of the access.
  logic mapped; // Address names a register.
  logic setup; // Setup cycle of a transfer.
  logic wr; // Write takes effect this cycle.
  logic rd_clr; // Source read completes this cycle.
  logic load_q; // A new event landed at the last edge.

  assign idx = paddr[APB_AW-1:2];
  assign mapped = (paddr[1:0] == 2'b00)
               && (idx == CONFIG_IDX || idx == SOURCE_IDX
                || idx == THRESH_IDX || idx == COUNT_IDX
                || idx == IRQ_STAT_IDX || idx == IRQ_CLR_IDX
                || idx == IRQ_EN_IDX);
  assign setup = psel && !penable;
  // No wait states: data is fetched in setup, so access ends at once.
  assign pready = psel && penable;
  assign wr = psel && penable && pwrite && mapped;
  // The read word was fetched in setup; an event that landed at that
  // same edge is not in it, so this read must not clear it.
  assign rd_clr = psel && penable && !pwrite && !load_q
               && paddr[1:0] == 2'b00 && idx == SOURCE_IDX;

  // ----------------------------------------------------------------
  // Source register
  // ----------------------------------------------------------------
  // A new event in the cycle of a read wins, so it is never lost.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src <= SOURCE_RST;
    end else if (load) begin
      src <= next_src;
    end else if (accel.tick && !cfg.latch_en) begin
      src <= SOURCE_RST;
    end else if (rd_clr) begin
      src <= SOURCE_RST;
    end
  end

  // Remembers a load for one cycle, for the read-clear guard.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load;
    end
  end

  assign event_active = src.any_event_active;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Reserved configuration bits stay zero whatever is written.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= CONFIG_RST;
    end else if (wr && idx == CONFIG_IDX) begin
      cfg <= {3'b000, pwdata[4:0]};
    end
  end

  // Threshold and debounce mode share one register.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ths <= THRESH_RST;
    end else if (wr && idx == THRESH_IDX) begin
      ths <= pwdata[7:0];
    end
  end

  // Debounce step count.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      debounce_value <= COUNT_RST;
    end else if (wr && idx == COUNT_IDX) begin
      debounce_value <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------
  // Write-one-to-clear; a set in the same cycle takes priority.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= 1'b0;
    end else begin
      irq_status <= evt
        | (irq_status & ~(wr && idx == IRQ_CLR_IDX && pwdata[0]));
    end
  end

  // Interrupt enable bit.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en <= 1'b0;
    end else if (wr && idx == IRQ_EN_IDX) begin
      irq_en <= pwdata[0];
    end
  end

  assign irq = irq_status & irq_en;

  // ----------------------------------------------------------------
  // Read data and error answer
  // ----------------------------------------------------------------
  // Data is registered in setup and held through the access phase.
  // The clear register reads as zero since it stores nothing.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      prdata <= '0;
      if (!pwrite && paddr[1:0] == 2'b00) begin
        unique case (idx)
          CONFIG_IDX: prdata <= {24'h000000, cfg};
          SOURCE_IDX: prdata <= {24'h000000, src};
          THRESH_IDX: prdata <= {24'h000000, ths};
          COUNT_IDX: prdata <= {24'h000000, debounce_value};
          IRQ_STAT_IDX: prdata <= {31'h00000000, irq_status};
          IRQ_EN_IDX: prdata <= {31'h00000000, irq_en};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence trig_s;
    accel.tick && hit && !src.any_event_active;
  endsequence

  sequence src_read_s;
    rd_clr && !load && !(accel.tick && !cfg.latch_en);
  endsequence

  event_sets_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    trig_s |=> src.any_event_active && irq_status)
    else $error("trigger did not set event and status");

  rt_follow_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !cfg.latch_en && accel.tick && !hit |=> !src.any_event_active)
    else $error("unlatched flag did not follow detection");

  read_clear_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    src_read_s |=> src == SOURCE_RST)
    else $error("source read did not clear flags");

  latch_hold_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cfg.latch_en && src.any_event_active && !rd_clr
      |=> src == $past(src))
    else $error("latched source changed before read");

  axis_mask_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    load && !cfg.axis_en[0] |=> !src.pair[0][1])
    else $error("disabled X axis raised a flag");

  any_flag_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    src.any_event_active == (src.pair[0][1] | src.pair[1][1]
                           | src.pair[2][1]))
    else $error("any-event flag disagrees with axis flags");

  polarity_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    load && over[1] |=> src.pair[1][0] == $past(neg[1]))
    else $error("Y polarity does not match excursion sign");

  cnt_clear_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    accel.tick && !cond && ths.debounce_mode |=> deb_cnt == 8'h00)
    else $error("debounce counter not cleared");

  cnt_dec_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    accel.tick && !cond && !ths.debounce_mode && deb_cnt != 8'h00
      |=> deb_cnt == $past(deb_cnt) - 8'h01)
    else $error("debounce counter not decremented");

  cnt_idle_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !accel.tick |=> deb_cnt == $past(deb_cnt))
    else $error("debounce counter moved without a tick");

  cfg_layout_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    setup && !pwrite && paddr == {CONFIG_IDX, 2'b00}
      |=> prdata[7:5] == 3'b000 && prdata[4:0] == cfg[4:0])
    else $error("config readback layout wrong");

  bypass_sel_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !cfg.hpf_bypass |-> sel[2] == filt[2])
    else $error("filtered data not selected");

  fresh_keep_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    load_q && cfg.latch_en && src.any_event_active
      |=> src.any_event_active)
    else $error("fresh latched event cleared by a stale read");

  set_wins_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    evt && wr && idx == IRQ_CLR_IDX && pwdata[0] |=> irq_status)
    else $error("status clear beat a new event");

endmodule // transient_detector

// ===== sim/host_model.sv
// Host processor model: APB master for the detector registers.
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // --------------------------------------------------------------
  // Idle bus at time zero
  // --------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the request holds until pready is seen high or 20 access cycles pass.
  // Reading the source word is how the host clears a held event.
  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er, output logic ok);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 20) begin
      @(posedge core_clk);
      n++;
      ok = (pready === 1'b1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so stale values are not trusted.
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // host_model

// ===== sim/transient_detector_tb.sv
// Self-checking bench for the transient event detector.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
  end end
module transient_detector_tb;
  import transient_pkg::*;
  logic core_clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  accel_in_t accel;
  logic event_active;
  logic irq;
  int error_cnt;
  int total_checks;

  transient_detector DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accel(accel), .event_active(event_active),
    .irq(irq));

  host_model host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // --------------------------------------------------------------
  // Clock and shared tasks
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bus access; the delay lets the completing edge's updates land.
  task automatic acc(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    logic ok;
    host.xfer(w, idx, wd, rd, er, ok);
    if (!ok) begin
      error_cnt++;
      stop_test();
    end
    #1;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic er;
    acc(1'b1, idx, {24'h000000, d}, rd, er);
    `CHK(er, 1'b0);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    acc(1'b0, idx, 32'h0000_0000, rd, er);
    `CHK(er, 1'b0);
    `CHK(rd, e);
  endtask

  // One sample tick with X, Y, Z; results are settled on return.
  task automatic smp(input int x, input int y, input int z);
    @(posedge core_clk);
    accel.tick <= 1'b1;
    accel.axis[0] <= x[13:0];
    accel.axis[1] <= y[13:0];
    accel.axis[2] <= z[13:0];
    @(posedge core_clk);
    accel.tick <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  // Threshold (with mode bit), debounce count and config in one go.
  task automatic setup(input logic [7:0] ths, input logic [7:0] cnt,
                       input logic [7:0] cfg);
    wr(THRESH_IDX, ths);
    wr(COUNT_IDX, cnt);
    wr(CONFIG_IDX, cfg);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    logic er;
    rd_chk(CONFIG_IDX, 32'h0000_0000);
    rd_chk(SOURCE_IDX, 32'h0000_0000);
    rd_chk(THRESH_IDX, 32'h0000_0000);
    rd_chk(COUNT_IDX, 32'h0000_0000);
    // An unmapped word must refuse and read zero.
    acc(1'b0, 10'h3FF, 32'h0000_0000, rd, er);
    `CHK(er, 1'b1);
    `CHK(rd, 32'h0000_0000);
    // Mode bit and threshold share one word and read back whole.
    wr(THRESH_IDX, 8'h85);
    rd_chk(THRESH_IDX, 32'h0000_0085);
    wr(CONFIG_IDX, 8'hFF);
    rd_chk(CONFIG_IDX, 32'h0000_001F);
  endtask

  // Bypass path, unlatched: polarity, axis enables, strict threshold.
  task automatic t_detect();
    setup(8'h01, 8'h00, 8'h07);
    smp(64, 0, 0);
    `CHK(event_active, 1'b0);
    smp(65, 0, 0);
    `CHK(event_active, 1'b1);
    smp(0, 0, 0);
    `CHK(event_active, 1'b0);
    smp(0, -100, 0);
    rd_chk(SOURCE_IDX, 32'h0000_004C);
    smp(-100, 0, 0);
    rd_chk(SOURCE_IDX, 32'h0000_0043);
    smp(0, 0, 500);
    `CHK(event_active, 1'b0);
    wr(CONFIG_IDX, 8'h0F);
    smp(100, -100, 100);
    rd_chk(SOURCE_IDX, 32'h0000_006E);
  endtask

  // Count of 3: a quiet tick decrements in mode 0 and clears in mode 1.
  task automatic t_debounce();
    for (int m = 0; m < 2; m++) begin
      setup({m[0], 7'h01}, 8'h03, 8'h03);
      repeat (8) smp(0, 0, 0);
      smp(100, 0, 0);
      smp(100, 0, 0);
      smp(0, 0, 0);
      smp(100, 0, 0);
      smp(100, 0, 0);
      `CHK(event_active, (m == 0));
      smp(100, 0, 0);
      `CHK(event_active, 1'b1);
    end
  endtask

  // Latched: first event freezes until the source word is read.
  task automatic t_latch();
    setup(8'h01, 8'h00, 8'h07);
    smp(0, 0, 0);
    wr(CONFIG_IDX, 8'h17);
    smp(100, 0, 0);
    smp(0, -100, 0);
    smp(0, 0, 0);
    `CHK(event_active, 1'b1);
    rd_chk(SOURCE_IDX, 32'h0000_0042);
    rd_chk(SOURCE_IDX, 32'h0000_0000);
    `CHK(event_active, 1'b0);
  endtask

  // A steady offset fades through the filter but not when bypassed.
  task automatic t_hpf();
    setup(8'h01, 8'h00, 8'h02);
    repeat (200) smp(100, 0, 0);
    `CHK(event_active, 1'b0);
    smp(1000, 0, 0);
    smp(1000, 0, 0);
    `CHK(event_active, 1'b1);
    repeat (200) smp(100, 0, 0);
    wr(CONFIG_IDX, 8'h03);
    smp(100, 0, 0);
    `CHK(event_active, 1'b1);
  endtask

  // Sticky status, enable mask and write-one clear of the interrupt.
  task automatic t_irq();
    setup(8'h01, 8'h00, 8'h03);
    smp(0, 0, 0);
    // Earlier scenarios left the sticky bit set, so start from clear.
    wr(IRQ_CLR_IDX, 8'h01);
    wr(IRQ_EN_IDX, 8'h01);
    `CHK(irq, 1'b0);
    smp(100, 0, 0);
    `CHK(irq, 1'b1);
    rd_chk(IRQ_STAT_IDX, 32'h0000_0001);
    smp(0, 0, 0);
    `CHK(irq, 1'b1);
    wr(IRQ_CLR_IDX, 8'h01);
    `CHK(irq, 1'b0);
    rd_chk(IRQ_STAT_IDX, 32'h0000_0000);
    wr(IRQ_EN_IDX, 8'h00);
    smp(100, 0, 0);
    `CHK(irq, 1'b0);
    rd_chk(IRQ_STAT_IDX, 32'h0000_0001);
    wr(IRQ_EN_IDX, 8'h01);
    `CHK(irq, 1'b1);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    accel = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_detect();
    t_debounce();
    t_latch();
    t_hpf();
    t_irq();
    stop_test();
  end
endmodule // transient_detector_tb
